/* File: hdl/supervisor_pkg.sv */
/*
 * Constants for the safety state and fault supervisor: operating states,
 * register map of the plain register port, field positions, reset values
 * and timing figures.
 * Assumes a single 200 MHz clock and the plain address/strobe register port.
 */
package supervisor_pkg;

    // Operating states, also shown on the indicator outputs
    typedef enum logic [2:0] {
        ST_INIT      = 3'b000,
        ST_STOP_OK   = 3'b001,
        ST_STOP_BAD  = 3'b010,
        ST_RUN       = 3'b011,
        ST_FAULT_HLT = 3'b100
    } op_state_e;

    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned RESTART_S    = 60;
    localparam int unsigned PERSIST_H    = 24;
    localparam longint unsigned RESTART_CYC = longint'(RESTART_S) * CLK_HZ;
    localparam longint unsigned PERSIST_CYC = longint'(PERSIST_H) * 3600 * CLK_HZ;

    // Default fault frequency limit and window and watchdog limit, all configurable
    localparam logic [7:0]  FREQ_LIMIT_RST  = 8'h04;
    localparam logic [31:0] FREQ_WIN_RST    = 32'h0BEB_C200;
    localparam logic [31:0] WDOG_LIMIT_RST  = 32'h0001_0000;

    // Register indices (word addresses)
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_STATUS    = 8'h01;
    localparam logic [7:0] A_FREQ_LIM  = 8'h02;
    localparam logic [7:0] A_FREQ_WIN  = 8'h03;
    localparam logic [7:0] A_WDOG_LIM  = 8'h04;
    localparam logic [7:0] A_INIT_VAL  = 8'h05;
    localparam logic [7:0] A_MOD_FLT   = 8'h06;
    localparam logic [7:0] A_MOD_LATCH = 8'h07;
    localparam logic [7:0] A_MOD_OFF   = 8'h08;
    localparam logic [7:0] A_FLT_CODE  = 8'h09;
    localparam logic [7:0] A_APP_PARAM = 8'h0A;

    // Control register bits (run, stop and reboot act on a one and are pulses; the other bits hold the value written)
    localparam int unsigned C_RUN_REQ    = 0;
    localparam int unsigned C_STOP_REQ   = 1;
    localparam int unsigned C_REBOOT     = 2;
    localparam int unsigned C_CFG_VALID  = 3;
    localparam int unsigned C_LEGACY     = 4;
    localparam int unsigned C_USE_INIT   = 5;

    // Fault type codes
    localparam logic [3:0] FC_NONE      = 4'h0;
    localparam logic [3:0] FC_INPUT     = 4'h1;
    localparam logic [3:0] FC_OUTPUT    = 4'h2;
    localparam logic [3:0] FC_MODULE    = 4'h3;
    localparam logic [3:0] FC_SWITCHOFF = 4'h4;
    localparam logic [3:0] FC_INTERNAL  = 4'h5;
    localparam logic [3:0] FC_TIMEOUT   = 4'h6;

endpackage

/* File: hdl/safety_state_fault_supervisor.sv */
/*
 * Safety state and fault supervisor: operating state sequencer, per-channel
 * input substitution and output switch-off, module fault tracking with
 * frequency statistic and persistence shutdown, internal fault restarts and
 * time monitoring of tests, cycles and I/O processing.
 * Assumes synchronous inputs, one clock and a register master that never
 * issues read and write together. Terminal commands arrive via registers.
 */
module safety_state_fault_supervisor
    import supervisor_pkg::*;
#(
    parameter int unsigned     CH         = 8,
    parameter int unsigned     MODS       = 4,
    parameter longint unsigned RESTART_N  = RESTART_CYC,
    parameter longint unsigned PERSIST_N  = PERSIST_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // I/O bus side: per channel, per module, then shared signals
    input  wire logic [MODS*CH-1:0] in_raw,
    input  wire logic [MODS*CH-1:0] in_fault,
    input  wire logic [MODS*CH-1:0] out_fault,
    input  wire logic [MODS-1:0]    out_single_off_ok,
    input  wire logic [MODS-1:0]    mod_fault,
    input  wire logic               secondary_off_fail,
    input  wire logic               internal_fault,
    input  wire logic               test_done,
    input  wire logic               cycle_done,
    input  wire logic               io_done,
    // Application side
    input  wire logic [MODS*CH-1:0] app_out,
    input  wire logic               emergency_halt_flag,
    output logic [MODS*CH-1:0]      app_in,
    output logic [MODS*CH-1:0]      out_drive,
    output logic                    fault_status,
    output logic [3:0]              fault_code,
    output logic                    app_enable,
    output logic                    io_enable,
    output logic                    comm_enable,
    output logic                    selftest_enable,
    output logic                    wdog_off,
    output logic [2:0]              indicator
);
    localparam int unsigned N = MODS * CH;

    op_state_e         state_q, state_d;
    logic [N-1:0]      app_in_q, out_drive_q;

    logic [MODS-1:0]   flt_q, latch_q, off_q, prev_mod_q;
    logic [7:0]        freq_cnt_q [MODS];
    logic [47:0]       persist_q [MODS];
    logic [31:0]       win_cnt_q;
    logic [39:0]       restart_q;
    logic              restart_win_q;

    logic [31:0]       wdog_q;
    logic [7:0]        freq_lim_q;
    logic [31:0]       freq_win_q, wdog_lim_q;
    logic [N-1:0]      init_val_q;
    logic [31:0]       app_param_q;

    logic              cfg_valid_q, legacy_q, use_init_q;
    logic              fault_status_q, wdog_off_q;
    logic [3:0]        fault_code_q, fault_code_d;
    logic [31:0]       reg_rdata_q, rd_mux;

    logic [2:0]        indicator_q;
    logic              app_en_q, io_en_q, comm_en_q, test_en_q;

    // Register decode
    wire wr_ctrl   = reg_wr && reg_addr == A_CTRL;
    wire run_cmd   = wr_ctrl && reg_wdata[C_RUN_REQ];
    wire stop_cmd  = wr_ctrl && reg_wdata[C_STOP_REQ];
    wire reboot    = wr_ctrl && reg_wdata[C_REBOOT];

    wire mon_evt   = test_done || cycle_done || io_done;
    wire timeout   = wdog_q >= wdog_lim_q;

    // Modules whose faulty channel cannot be switched alone
    logic [MODS-1:0] out_mod_flt;
    logic [MODS-1:0] any_in_flt;
    always_comb begin
        for (int m = 0; m < MODS; m++) begin
            out_mod_flt[m] = |out_fault[m*CH +: CH] && !out_single_off_ok[m];
            any_in_flt[m]  = |in_fault[m*CH +: CH];
        end
    end

    // Output cannot be removed by any path
    wire offpath_fail = |out_mod_flt && secondary_off_fail;
    wire win_end      = win_cnt_q >= freq_win_q;

    // State sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_INIT:
                if (test_done) begin
                    state_d = cfg_valid_q ? ST_STOP_OK : ST_STOP_BAD;
                end

            ST_STOP_OK:
                if (!cfg_valid_q) begin
                    state_d = ST_STOP_BAD;
                end else if (run_cmd && !emergency_halt_flag) begin
                    state_d = ST_RUN;
                end

            ST_STOP_BAD:
                if (reboot) begin
                    state_d = ST_INIT;
                end

            ST_RUN:
                // Emergency halt, stop on dead switch-off
                if (emergency_halt_flag || stop_cmd || offpath_fail || timeout) begin
                    state_d = ST_STOP_OK;
                end else if (!cfg_valid_q) begin
                    state_d = ST_STOP_BAD;
                end

            ST_FAULT_HLT:
                if (reboot) begin
                    state_d = ST_INIT;
                end

            default: state_d = ST_STOP_BAD;
        endcase

        if (internal_fault && state_q != ST_STOP_BAD && state_q != ST_FAULT_HLT) begin
            if (legacy_q) begin
                state_d = ST_FAULT_HLT;
            end else if (restart_win_q) begin
                state_d = ST_STOP_BAD;
            end else begin
                state_d = ST_INIT;
            end
        end
    end

    wire go_run = state_q == ST_STOP_OK && state_d == ST_RUN;
    wire running = state_q == ST_RUN;

    always_comb begin
        fault_code_d = FC_NONE;
        if (internal_fault) begin
            fault_code_d = FC_INTERNAL;
        end else if (offpath_fail) begin
            fault_code_d = FC_SWITCHOFF;
        end else if (timeout) begin
            fault_code_d = FC_TIMEOUT;
        end else if (|(mod_fault | out_mod_flt)) begin
            fault_code_d = FC_MODULE;
        end else if (|out_fault) begin
            fault_code_d = FC_OUTPUT;
        end else if (|in_fault) begin
            fault_code_d = FC_INPUT;
        end
    end

    // Register readback
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr)
            A_CTRL:      rd_mux = {26'h0, use_init_q, legacy_q, cfg_valid_q, 3'h0};
            A_STATUS:    rd_mux = {24'h0, fault_code_q, fault_status_q, state_q};
            A_FREQ_LIM:  rd_mux = {24'h0, freq_lim_q};
            A_FREQ_WIN:  rd_mux = freq_win_q;
            A_WDOG_LIM:  rd_mux = wdog_lim_q;
            A_INIT_VAL:  rd_mux = 32'(init_val_q);
            A_MOD_FLT:   rd_mux = 32'(flt_q);
            A_MOD_LATCH: rd_mux = 32'(latch_q);
            A_MOD_OFF:   rd_mux = 32'(off_q);
            A_FLT_CODE:  rd_mux = {28'h0, fault_code_q};
            A_APP_PARAM: rd_mux = app_param_q;
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // Configuration registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_valid_q <= 1'b0;
            legacy_q    <= 1'b0;
            use_init_q  <= 1'b0;
            freq_lim_q  <= FREQ_LIMIT_RST;
            freq_win_q  <= FREQ_WIN_RST;
            wdog_lim_q  <= WDOG_LIMIT_RST;
            init_val_q  <= '0;
            app_param_q <= 32'h0000_0000;
            reg_rdata_q <= 32'h0000_0000;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
            if (wr_ctrl) begin
                cfg_valid_q <= reg_wdata[C_CFG_VALID];
                legacy_q    <= reg_wdata[C_LEGACY];
                use_init_q  <= reg_wdata[C_USE_INIT];
            end

            if (reg_wr && reg_addr == A_FREQ_LIM) freq_lim_q <= reg_wdata[7:0];
            if (reg_wr && reg_addr == A_FREQ_WIN) freq_win_q <= reg_wdata;
            if (reg_wr && reg_addr == A_WDOG_LIM) wdog_lim_q <= reg_wdata;
            if (reg_wr && reg_addr == A_INIT_VAL) init_val_q <= reg_wdata[N-1:0];
            if (reg_wr && reg_addr == A_APP_PARAM) app_param_q <= reg_wdata;
        end
    end

    // State, monitors and restart window
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q       <= ST_INIT;
            wdog_q        <= 32'h0000_0000;
            restart_q     <= 40'h00_0000_0000;
            restart_win_q <= 1'b0;
            win_cnt_q     <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            // Restarted by each finished test, cycle or I/O step
            wdog_q <= (mon_evt || state_d != state_q) ? 32'h0000_0000 : wdog_q + 32'h0000_0001;
            // One-minute window from each automatic restart
            if (internal_fault && !legacy_q && !restart_win_q) begin
                restart_q     <= 40'h00_0000_0000;
                restart_win_q <= 1'b1;
            end else if (restart_win_q) begin
                restart_q <= restart_q + 40'h00_0000_0001;
                if (restart_q >= 40'(RESTART_N - 1)) restart_win_q <= 1'b0;
            end
            win_cnt_q <= (win_end || go_run) ? 32'h0000_0000 : win_cnt_q + 32'h0000_0001;
        end
    end

    // Per-module fault tracking
    for (genvar m = 0; m < MODS; m++) begin : g_mod
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                flt_q[m]      <= 1'b0;
                latch_q[m]    <= 1'b0;
                off_q[m]      <= 1'b0;
                prev_mod_q[m] <= 1'b0;
                freq_cnt_q[m] <= 8'h00;
                persist_q[m]  <= 48'h0000_0000_0000;
            end else begin
                prev_mod_q[m] <= mod_fault[m];
                // Status follows the fault; whole module on switch-off limit
                flt_q[m] <= mod_fault[m] || out_mod_flt[m];

                if (mod_fault[m] || out_mod_flt[m]) begin
                    if (persist_q[m] < 48'(PERSIST_N)) persist_q[m] <= persist_q[m] + 48'h1;
                end else begin
                    persist_q[m] <= 48'h0000_0000_0000;
                end

                // Permanent switch-off of this module only
                if (persist_q[m] >= 48'(PERSIST_N)) off_q[m] <= 1'b1;

                if (go_run) begin
                    latch_q[m]    <= 1'b0;
                    freq_cnt_q[m] <= 8'h00;
                end else begin
                    // Count onsets in window, latch on excess
                    if (mod_fault[m] && !prev_mod_q[m]) begin
                        freq_cnt_q[m] <= freq_cnt_q[m] + 8'h01;
                    end else if (win_end) begin
                        freq_cnt_q[m] <= 8'h00;
                    end
                    if (freq_cnt_q[m] > freq_lim_q) latch_q[m] <= 1'b1;
                end
            end
        end
    end

    wire [MODS-1:0] mod_dead = flt_q | latch_q | off_q;
    wire safe_out = !running;

    // Channel substitution and output gating
    logic [N-1:0] app_in_d, out_drive_d;
    always_comb begin
        for (int i = 0; i < N; i++) begin
            // Safe value or initial value; per channel
            app_in_d[i] = (in_fault[i] || mod_dead[i/CH])
                        ? (use_init_q && init_val_q[i])
                        : in_raw[i];
            // Faulty channel de-energized; stop resets all
            out_drive_d[i] = app_out[i] && !out_fault[i] && !mod_dead[i/CH] && !safe_out;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            app_in_q       <= '0;
            out_drive_q    <= '0;
            fault_status_q <= 1'b0;
            fault_code_q   <= FC_NONE;
            wdog_off_q     <= 1'b0;
            indicator_q    <= ST_INIT;
            app_en_q       <= 1'b0;
            io_en_q        <= 1'b0;
            comm_en_q      <= 1'b0;
            test_en_q      <= 1'b0;
        end else begin
            app_in_q    <= app_in_d;
            out_drive_q <= out_drive_d;
            fault_status_q <= fault_code_d != FC_NONE || |mod_dead || |any_in_flt;
            fault_code_q   <= fault_code_d;

            if (offpath_fail) wdog_off_q <= 1'b1;
            else if (reboot) wdog_off_q <= 1'b0;

            indicator_q <= state_d;
            // Run enables app, I/O bus, comm
            app_en_q  <= state_d == ST_RUN;
            io_en_q   <= state_d == ST_RUN;
            comm_en_q <= state_d == ST_RUN;
            test_en_q <= state_d != ST_STOP_BAD && state_d != ST_FAULT_HLT;
        end
    end

    assign reg_rdata       = reg_rdata_q;
    assign app_in          = app_in_q;
    assign out_drive       = out_drive_q;
    assign fault_status    = fault_status_q;
    assign fault_code      = fault_code_q;
    assign wdog_off        = wdog_off_q;
    assign indicator       = indicator_q;
    assign app_enable      = app_en_q;
    assign io_enable       = io_en_q;
    assign comm_enable     = comm_en_q;
    assign selftest_enable = test_en_q;
endmodule

/* File: tb/supervisor_checker.sv */
/* Port assertions for the supervisor.
   Assumes it is bound into the design top, one clock domain. */
module supervisor_checker
    import supervisor_pkg::*;
#(
    parameter int unsigned CH   = 8,
    parameter int unsigned MODS = 4
) (
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire logic [7:0]         reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [31:0]        reg_rdata,
    input wire logic [MODS*CH-1:0] in_fault,
    input wire logic [MODS*CH-1:0] out_fault,
    input wire logic               test_done,
    input wire logic               internal_fault,
    input wire logic               emergency_halt_flag,
    input wire logic [MODS*CH-1:0] app_in,
    input wire logic [MODS*CH-1:0] out_drive,
    input wire logic               fault_status,
    input wire logic [3:0]         fault_code,
    input wire logic               app_enable,
    input wire logic               io_enable,
    input wire logic [2:0]         indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic use_init_q;
    // Mirror of the stored substitution choice
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            use_init_q <= 1'b0;
        end else if (reg_wr && reg_addr == A_CTRL) begin
            use_init_q <= reg_wdata[C_USE_INIT];
        end
    end
    sequence emerg_run_s;
        indicator == ST_RUN && emergency_halt_flag;
    endsequence
    sequence status_read_s;
        reg_rd && reg_addr == A_STATUS;
    endsequence
    a_in_sub_zero: assert property (!$past(use_init_q) |-> (app_in & $past(in_fault)) == '0)
        else $error("faulty input not zero");
    a_out_flt_off: assert property ((out_drive & $past(out_fault)) == '0)
        else $error("faulty output energized");
    a_stop_out_rst: assert property (indicator != ST_RUN && $past(indicator) != ST_RUN
        |-> out_drive == '0 && !app_enable) else $error("outputs live outside run");
    a_run_enables: assert property (indicator == ST_RUN |-> app_enable && io_enable)
        else $error("run without app or io");
    a_emerg_stop: assert property (emerg_run_s |-> ##[1:2] indicator != ST_RUN)
        else $error("halt flag ignored");
    a_bad_holds: assert property (indicator == ST_STOP_BAD
        && !(reg_wr && reg_addr == A_CTRL && reg_wdata[C_REBOOT]) |=> indicator == ST_STOP_BAD)
        else $error("left stop invalid without reboot");
    a_init_leave: assert property ($past(indicator) == ST_INIT && indicator != ST_INIT
        |-> $past(test_done) || $past(internal_fault)) else $error("init left early");
    a_fault_code: assert property ($rose(fault_status) |-> fault_code != FC_NONE)
        else $error("fault without code");
    a_state_read: assert property (status_read_s |=> reg_rdata[2:0] == $past(indicator))
        else $error("status read wrong state");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data outside read");
endmodule

bind safety_state_fault_supervisor supervisor_checker #(.CH(CH), .MODS(MODS)) i_sup_chk (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_fault(in_fault),
    .out_fault(out_fault), .test_done(test_done), .internal_fault(internal_fault),
    .emergency_halt_flag(emergency_halt_flag), .app_in(app_in), .out_drive(out_drive),
    .fault_status(fault_status), .fault_code(fault_code), .app_enable(app_enable),
    .io_enable(io_enable), .indicator(indicator));

/* File: tb/io_module_model.sv */
/* Behavioural I/O modules on the internal bus.
   Assumes the bench names readings and fault patterns. */
module io_module_model #(
    parameter int unsigned N    = 32,
    parameter int unsigned MODS = 4
) (
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic [N-1:0]    reading,
    input  wire logic [N-1:0]    inj_in,
    input  wire logic [N-1:0]    inj_out,
    input  wire logic [MODS-1:0] inj_mod,
    input  wire logic [MODS-1:0] solo_ok,
    output logic [N-1:0]         in_raw,
    output logic [N-1:0]         in_fault,
    output logic [N-1:0]         out_fault,
    output logic [MODS-1:0]      out_single_off_ok,
    output logic [MODS-1:0]      mod_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {in_raw, in_fault, out_fault, mod_fault} <= '0;
            out_single_off_ok <= '1;
        end else begin
            in_raw <= reading;
            in_fault <= inj_in;
            out_fault <= inj_out;
            mod_fault <= inj_mod;
            out_single_off_ok <= solo_ok;
        end
    end
endmodule

/* File: tb/safety_state_fault_supervisor_tb_top.sv */
/* Bench for the supervisor: state walks and random channel traffic.
   Assumes CH 8, MODS 4 and short restart and persistence counts. */
module safety_state_fault_supervisor_tb_top
    import supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 32;
    localparam logic [31:0] CFG = 32'h0000_0001 << C_CFG_VALID;
    localparam logic [31:0] RUNB = 32'h0000_0001 << C_RUN_REQ;
    localparam logic [31:0] STP = 32'h0000_0001 << C_STOP_REQ;
    localparam logic [31:0] BOOT = 32'h0000_0001 << C_REBOOT;
    localparam logic [31:0] LEG = 32'h0000_0001 << C_LEGACY;
    localparam logic [31:0] UI = 32'h0000_0001 << C_USE_INIT;
    logic         ref_clk, rst, reg_wr, reg_rd, alive, sec_fail, int_fault, emerg;
    logic [7:0]   reg_addr, tick = 8'h00;
    logic [31:0]  reg_wdata, reg_rdata, d;
    logic [N-1:0] reading, inj_in, inj_out, app_out, in_raw, in_fault, out_fault;
    logic [N-1:0] app_in, out_drive;
    logic [3:0]   inj_mod, solo, single_ok, mod_fault, fault_code;
    logic         test_done, cycle_done, io_done, fault_status, app_enable, io_enable;
    logic         comm_enable, selftest_enable, wdog_off;
    logic [2:0]   indicator;
    int           n_mismatch = 0;
    int           n_tests = 0;

    io_module_model #(.N(N), .MODS(4)) i_io_module_model (
        .ref_clk(ref_clk), .rst(rst), .reading(reading), .inj_in(inj_in),
        .inj_out(inj_out), .inj_mod(inj_mod), .solo_ok(solo), .in_raw(in_raw),
        .in_fault(in_fault), .out_fault(out_fault), .out_single_off_ok(single_ok),
        .mod_fault(mod_fault));
    safety_state_fault_supervisor #(.CH(8), .MODS(4), .RESTART_N(50), .PERSIST_N(100))
        i_safety_state_fault_supervisor (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_raw(in_raw),
        .in_fault(in_fault), .out_fault(out_fault), .out_single_off_ok(single_ok),
        .mod_fault(mod_fault), .secondary_off_fail(sec_fail), .internal_fault(int_fault),
        .test_done(test_done), .cycle_done(cycle_done), .io_done(io_done),
        .app_out(app_out), .emergency_halt_flag(emerg), .app_in(app_in),
        .out_drive(out_drive), .fault_status(fault_status), .fault_code(fault_code),
        .app_enable(app_enable), .io_enable(io_enable), .comm_enable(comm_enable),
        .selftest_enable(selftest_enable), .wdog_off(wdog_off), .indicator(indicator));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Keeps the time monitors fed unless a scenario starves them
    always @(posedge ref_clk) begin
        tick <= tick + 8'd1;
        {test_done, cycle_done, io_done} <= {3{alive && tick[4:0] == 5'd0}};
    end

    function automatic logic [31:0] exp_in(logic [31:0] raw, flt, iv, logic ui);
        return (raw & ~flt) | (ui ? (iv & flt) : 32'h0000_0000);
    endfunction
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task automatic wrr(logic [7:0] a, logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        d = reg_rdata;
        chk(nm, e, d);
        cyc(1);
    endtask
    task automatic wait_st(op_state_e s, int lim);
        int i;
        for (i = 0; i < lim && indicator !== s; i++) cyc(1);
        chk("indicator", 32'(s), 32'(indicator));
    endtask
    task automatic pulse_int();
        int_fault <= 1'b1;
        cyc(1);
        int_fault <= 1'b0;
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        int k;
        logic [31:0] raw, flt, ofl, ao, iv;
        rst = 1'b1;
        {reg_wr, reg_rd, alive, sec_fail, int_fault, emerg} = '0;
        {reg_addr, reg_wdata, reading, inj_in, inj_out, app_out} = '0;
        inj_mod = '0;
        solo = 4'hF;
        k = $urandom(32'ha248);
        cyc(4);
        rst <= 1'b0;
        cyc(2);
        chk("init", 32'(ST_INIT), 32'(indicator));
        rchk("status", A_STATUS, 32'(ST_INIT));
        rchk("freq_lim", A_FREQ_LIM, 32'(FREQ_LIMIT_RST));
        rchk("freq_win", A_FREQ_WIN, FREQ_WIN_RST);
        rchk("wdog_lim", A_WDOG_LIM, WDOG_LIMIT_RST);
        rchk("unmapped", 8'h3F, 32'h0000_0000);
        chk("still init", 32'(ST_INIT), 32'(indicator));
        alive <= 1'b1;
        wait_st(ST_STOP_BAD, 80);
        wrr(A_CTRL, CFG | RUNB);
        chk("run refused", 32'(ST_STOP_BAD), 32'(indicator));
        wrr(A_CTRL, CFG | BOOT);
        wait_st(ST_STOP_OK, 80);
        emerg <= 1'b1;
        wrr(A_CTRL, CFG | RUNB);
        chk("halted run", 32'(ST_STOP_OK), 32'(indicator));
        emerg <= 1'b0;
        wrr(A_CTRL, CFG | RUNB);
        wait_st(ST_RUN, 3);
        emerg <= 1'b1;
        wait_st(ST_STOP_OK, 4);
        chk("stop out", 32'h0000_0000, out_drive);
        emerg <= 1'b0;
        wrr(A_CTRL, CFG | RUNB);
        iv = $urandom;
        for (k = 0; k < 16; k++) begin
            if (k == 8) wrr(A_INIT_VAL, iv);
            if (k == 8) wrr(A_CTRL, CFG | UI);
            raw = $urandom;
            flt = (k == 0) ? '1 : (k == 1) ? '0 : $urandom & $urandom;
            ofl = (k == 1) ? '1 : $urandom & $urandom;
            ao = $urandom;
            reading <= raw;
            inj_in <= flt;
            inj_out <= ofl;
            app_out <= ao;
            cyc(4);
            chk("app_in", exp_in(raw, flt, iv, k >= 8), app_in);
            chk("out_drive", ao & ~ofl, out_drive);
            if (flt != 0) chk("fault_status", 32'h1, 32'(fault_status));
        end
        {inj_in, inj_out} <= '0;
        wrr(A_CTRL, CFG | STP);
        wrr(A_CTRL, CFG | RUNB);
        wait_st(ST_RUN, 3);
        for (k = 0; k < 5; k++) begin
            inj_mod <= 4'h1;
            cyc(4);
            if (k == 0) rchk("mod_flt set", A_MOD_FLT, 32'h0000_0001);
            if (k == 0) chk("code", 32'(FC_MODULE), 32'(fault_code));
            inj_mod <= 4'h0;
            cyc(4);
            if (k == 0) rchk("mod_flt clear", A_MOD_FLT, 32'h0000_0000);
        end
        rchk("latched", A_MOD_LATCH, 32'h0000_0001);
        wrr(A_CTRL, CFG | STP);
        wrr(A_CTRL, CFG | RUNB);
        rchk("released", A_MOD_LATCH, 32'h0000_0000);
        inj_mod <= 4'h2;
        cyc(120);
        inj_mod <= 4'h0;
        cyc(4);
        rchk("mod_off", A_MOD_OFF, 32'h0000_0002);
        pulse_int();
        wait_st(ST_INIT, 2);
        cyc(5);
        pulse_int();
        wait_st(ST_STOP_BAD, 4);
        wrr(A_CTRL, CFG | LEG | BOOT);
        wait_st(ST_STOP_OK, 80);
        wrr(A_CTRL, CFG | LEG | RUNB);
        wait_st(ST_RUN, 3);
        pulse_int();
        wait_st(ST_FAULT_HLT, 3);
        cyc(40);
        chk("halt held", 32'(ST_FAULT_HLT), 32'(indicator));
        chk("halt out", 32'h0, out_drive | 32'({app_enable, selftest_enable, comm_enable}));
        wrr(A_CTRL, CFG | BOOT);
        wait_st(ST_STOP_OK, 80);
        wrr(A_WDOG_LIM, 32'h0000_0040);
        rchk("wdog_lim", A_WDOG_LIM, 32'h0000_0040);
        wrr(A_CTRL, CFG | RUNB);
        alive <= 1'b0;
        wait_st(ST_STOP_OK, 200);
        chk("timeout code", 32'(FC_TIMEOUT), 32'(fault_code));
        alive <= 1'b1;
        wrr(A_CTRL, CFG | RUNB);
        solo <= 4'b1011;
        inj_out <= 32'h0001_0000;
        cyc(4);
        rchk("mod2 faulty", A_MOD_FLT, 32'h0000_0004);
        sec_fail <= 1'b1;
        wait_st(ST_STOP_OK, 8);
        chk("wdog_off", 32'h1, 32'(wdog_off));
        close_out();
    end
endmodule
